/* alu8_pkg.sv */
// Package for the 8-bit arithmetic and logic datapath: opcodes, flag layout, constants.
package alu8_pkg;

   // ----------------------------------------
   // Operation codes
   // ----------------------------------------
   typedef enum logic [4:0] {
      ALU8_OP_ADD,
      ALU8_OP_ADC,
      ALU8_OP_ADD_IMMEDIATE_WORD,
      ALU8_OP_SUB,
      ALU8_OP_SUBTRACT_CONSTANT,
      ALU8_OP_SBC,
      ALU8_OP_SUBTRACT_CONST_WITH_CARRY,
      ALU8_OP_SUBTRACT_IMMEDIATE_WORD,
      ALU8_OP_AND,
      ALU8_OP_ANDI,
      ALU8_OP_OR,
      ALU8_OP_ORI,
      ALU8_OP_BITWISE_EXCLUSIVE_OR,
      ALU8_OP_COM,
      ALU8_OP_NEG,
      ALU8_OP_SET_BITS_BY_MASK,
      ALU8_OP_CLEAR_BITS_BY_MASK
   } alu8_op_t;

   // ----------------------------------------
   // Status flags and request / answer carriers
   // ----------------------------------------
   typedef struct packed {
      logic h;
      logic s;
      logic v;
      logic n;
      logic z;
      logic c;
   } alu8_flags_t;

   typedef struct packed {
      logic valid;
      alu8_op_t op;
      logic [7:0] rd;
      logic [7:0] rd_high;
      logic [7:0] rr;
      logic [7:0] k;
      alu8_flags_t flags_in;
   } alu8_req_t;

   typedef struct packed {
      logic valid;
      logic word;
      logic [7:0] result;
      logic [7:0] result_high;
      alu8_flags_t flags;
   } alu8_rsp_t;

   localparam logic [7:0] ALU8_ALL_ONES = 8'h_ff;
   localparam logic [7:0] ALU8_ZERO = 8'h_00;
   localparam int ALU8_BYTE_CYCLES = 1;
   localparam int ALU8_WORD_CYCLES = 2;
   localparam logic [5:0] ALU8_WORD_IMM_MASK = 6'h_3f;

endpackage

/* alu8_core.sv */
// Top module of the 8-bit arithmetic and logic datapath.
`timescale 1ns/1ps
// ----------------------------------------
// Overview of operation
// - Add two registers, optional carry-in; flags Z C N V H; one cycle.
// - Add immediate to register pair; flags Z C N V S; two cycles.
// - Subtract register, optional carry; flags Z C N V H; one cycle.
// - Subtract constant from register; flags Z C N V H; one cycle.
// - Subtract constant and carry; flags Z C N V H; one cycle.
// - Subtract immediate from register pair; flags Z C N V S; two cycles.
// - AND with register or constant; flags Z N V only; one cycle.
// - OR with register or constant; flags Z N V; one cycle.
// - Exclusive-OR flags Z N V; complement is 0xFF minus value, flags Z C N V.
// - Set bits by ORing with mask; flags Z N V; one cycle.
// - Clear bits by ANDing with 0xFF minus mask; flags Z N V; one cycle.
// ----------------------------------------
module alu8_core (
   input wire logic clk_i,
   input wire logic rst_i,
   input alu8_pkg::alu8_req_t req_i,
   output logic busy_o,
   output alu8_pkg::alu8_rsp_t rsp_o
);

   typedef struct packed {
      logic busy;
      logic word_sub;
      logic [15:0] word_acc;
      logic [5:0] imm;
      alu8_pkg::alu8_flags_t flags_keep;
      alu8_pkg::alu8_rsp_t rsp;
   } alu8_state_t;

   alu8_state_t state_reg;
   alu8_state_t state_next;

   // ----------------------------------------
   // Byte add/subtract with flags
   // ----------------------------------------
   // Sub selects a - b - cin; borrow is reported in C. Flags not listed keep fi.
   function automatic alu8_pkg::alu8_flags_t arith_flags(input logic [7:0] a,
         input logic [7:0] b, input logic [7:0] r, input logic sub,
         input alu8_pkg::alu8_flags_t fi);
      alu8_pkg::alu8_flags_t f;
      f = fi;
      f.z = (r == alu8_pkg::ALU8_ZERO);
      f.n = r[7];
      if (sub) begin
         f.c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
         f.h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
         f.v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      end else begin
         f.c = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
         f.h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
         f.v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
      end
      return f;
   endfunction

   function automatic alu8_pkg::alu8_flags_t logic_flags(input logic [7:0] r,
         input alu8_pkg::alu8_flags_t fi);
      alu8_pkg::alu8_flags_t f;
      f = fi;
      f.z = (r == alu8_pkg::ALU8_ZERO);
      f.n = r[7];
      f.v = 1'b0;
      return f;
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] r;
      logic cin;
      logic [15:0] w;
      logic [15:0] wr;
      alu8_pkg::alu8_flags_t f;
      a = req_i.rd;
      b = req_i.rr;
      r = alu8_pkg::ALU8_ZERO;
      cin = req_i.flags_in.c;
      w = state_reg.word_acc;
      wr = 16'h_0000;
      f = req_i.flags_in;
      state_next = state_reg;
      state_next.rsp.valid = 1'b0;
      if (state_reg.busy) begin
         // Second cycle of a word operation: the pair result and its flags appear.
         if (state_reg.word_sub) begin
            wr = w - {10'h_000, state_reg.imm};
         end else begin
            wr = w + {10'h_000, state_reg.imm};
         end
         f = state_reg.flags_keep;
         f.z = (wr == 16'h_0000);
         f.n = wr[15];
         if (state_reg.word_sub) begin
            f.v = w[15] & ~wr[15];
            f.c = wr[15] & ~w[15];
         end else begin
            f.v = ~w[15] & wr[15];
            f.c = ~wr[15] & w[15];
         end
         f.s = f.n ^ f.v;
         state_next.busy = 1'b0;
         state_next.rsp.valid = 1'b1;
         state_next.rsp.word = 1'b1;
         state_next.rsp.result = wr[7:0];
         state_next.rsp.result_high = wr[15:8];
         state_next.rsp.flags = f;
      end else if (req_i.valid) begin
         state_next.rsp.valid = 1'b1;
         state_next.rsp.word = 1'b0;
         state_next.rsp.result_high = alu8_pkg::ALU8_ZERO;
         case (req_i.op)
            alu8_pkg::ALU8_OP_ADD, alu8_pkg::ALU8_OP_ADC: begin
               cin = (req_i.op == alu8_pkg::ALU8_OP_ADC) & req_i.flags_in.c;
               r = a + b + {7'h_00, cin};
               f = arith_flags(a, b, r, 1'b0, req_i.flags_in);
            end
            alu8_pkg::ALU8_OP_SUB, alu8_pkg::ALU8_OP_SBC: begin
               cin = (req_i.op == alu8_pkg::ALU8_OP_SBC) & req_i.flags_in.c;
               r = a - b - {7'h_00, cin};
               f = arith_flags(a, b, r, 1'b1, req_i.flags_in);
            end
            alu8_pkg::ALU8_OP_SUBTRACT_CONSTANT: begin
               b = req_i.k;
               r = a - b;
               f = arith_flags(a, b, r, 1'b1, req_i.flags_in);
            end
            alu8_pkg::ALU8_OP_SUBTRACT_CONST_WITH_CARRY: begin
               b = req_i.k;
               r = a - b - {7'h_00, req_i.flags_in.c};
               f = arith_flags(a, b, r, 1'b1, req_i.flags_in);
            end
            alu8_pkg::ALU8_OP_NEG: begin
               r = alu8_pkg::ALU8_ZERO - a;
               f = arith_flags(alu8_pkg::ALU8_ZERO, a, r, 1'b1, req_i.flags_in);
            end
            alu8_pkg::ALU8_OP_AND: begin
               r = a & b;
               f = logic_flags(r, req_i.flags_in);
            end
            alu8_pkg::ALU8_OP_ANDI: begin
               r = a & req_i.k;
               f = logic_flags(r, req_i.flags_in);
            end
            alu8_pkg::ALU8_OP_OR: begin
               r = a | b;
               f = logic_flags(r, req_i.flags_in);
            end
            alu8_pkg::ALU8_OP_ORI: begin
               r = a | req_i.k;
               f = logic_flags(r, req_i.flags_in);
            end
            alu8_pkg::ALU8_OP_BITWISE_EXCLUSIVE_OR: begin
               r = a ^ b;
               f = logic_flags(r, req_i.flags_in);
            end
            alu8_pkg::ALU8_OP_COM: begin
               r = alu8_pkg::ALU8_ALL_ONES - a;
               f = logic_flags(r, req_i.flags_in);
               f.c = 1'b1;
            end
            alu8_pkg::ALU8_OP_SET_BITS_BY_MASK: begin
               r = a | req_i.k;
               f = logic_flags(r, req_i.flags_in);
            end
            alu8_pkg::ALU8_OP_CLEAR_BITS_BY_MASK: begin
               r = a & (alu8_pkg::ALU8_ALL_ONES - req_i.k);
               f = logic_flags(r, req_i.flags_in);
            end
            alu8_pkg::ALU8_OP_ADD_IMMEDIATE_WORD,
            alu8_pkg::ALU8_OP_SUBTRACT_IMMEDIATE_WORD: begin
               // The pair is latched now and answered next cycle.
               state_next.rsp.valid = 1'b0;
               state_next.busy = 1'b1;
               state_next.word_sub = (req_i.op == alu8_pkg::ALU8_OP_SUBTRACT_IMMEDIATE_WORD);
               state_next.word_acc = {req_i.rd_high, req_i.rd};
               state_next.imm = req_i.k[5:0] & alu8_pkg::ALU8_WORD_IMM_MASK;
               state_next.flags_keep = req_i.flags_in;
               // The previous answer, with valid cleared, stands until the pair result replaces it.
               state_next.rsp.word = state_reg.rsp.word;
               state_next.rsp.result_high = state_reg.rsp.result_high;
               r = state_reg.rsp.result;
               f = state_reg.rsp.flags;
            end
            default: begin
               r = alu8_pkg::ALU8_ZERO;
               f = req_i.flags_in;
            end
         endcase
         state_next.rsp.result = r;
         state_next.rsp.flags = f;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rsp_o = state_reg.rsp;
   assign busy_o = state_reg.busy;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_word_two_cycles: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_i.valid && !busy_o && req_i.op == alu8_pkg::ALU8_OP_ADD_IMMEDIATE_WORD)
      |=> busy_o && !rsp_o.valid ##1 rsp_o.valid && rsp_o.word)
      else $error("word add did not answer on the second cycle");
   a_word_sub_value: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_i.valid && !busy_o && req_i.op == alu8_pkg::ALU8_OP_SUBTRACT_IMMEDIATE_WORD)
      |-> ##2 {rsp_o.result_high, rsp_o.result} ==
      $past({req_i.rd_high, req_i.rd}, 2) - {10'h_000, $past(req_i.k[5:0], 2)})
      else $error("word subtract result wrong");
   a_add_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_i.valid && !busy_o && req_i.op == alu8_pkg::ALU8_OP_ADD)
      |=> rsp_o.valid && rsp_o.result == $past(req_i.rd) + $past(req_i.rr))
      else $error("add result wrong");
   a_sub_borrow: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_i.valid && !busy_o && req_i.op == alu8_pkg::ALU8_OP_SUB)
      |=> rsp_o.flags.c == ($past(req_i.rr) > $past(req_i.rd)))
      else $error("subtract borrow wrong");
   a_subk_value: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_i.valid && !busy_o && req_i.op == alu8_pkg::ALU8_OP_SUBTRACT_CONSTANT)
      |=> rsp_o.result == $past(req_i.rd) - $past(req_i.k))
      else $error("subtract constant wrong");
   a_subkc_value: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_i.valid && !busy_o && req_i.op == alu8_pkg::ALU8_OP_SUBTRACT_CONST_WITH_CARRY)
      |=> rsp_o.result == $past(req_i.rd) - $past(req_i.k) - {7'h_00, $past(req_i.flags_in.c)})
      else $error("subtract constant with carry wrong");
   a_and_keeps_c: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_i.valid && !busy_o && req_i.op == alu8_pkg::ALU8_OP_AND)
      |=> !rsp_o.flags.v && rsp_o.flags.c == $past(req_i.flags_in.c))
      else $error("and touched carry or overflow");
   a_or_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_i.valid && !busy_o && req_i.op == alu8_pkg::ALU8_OP_OR)
      |=> rsp_o.flags.z == (($past(req_i.rd) | $past(req_i.rr)) == 8'h_00))
      else $error("or zero flag wrong");
   a_com_carry: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_i.valid && !busy_o && req_i.op == alu8_pkg::ALU8_OP_COM)
      |=> rsp_o.flags.c && rsp_o.result == ~$past(req_i.rd))
      else $error("complement wrong");
   a_set_bits: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_i.valid && !busy_o && req_i.op == alu8_pkg::ALU8_OP_SET_BITS_BY_MASK)
      |=> rsp_o.result == ($past(req_i.rd) | $past(req_i.k)))
      else $error("set bits wrong");
   a_clear_bits: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_i.valid && !busy_o && req_i.op == alu8_pkg::ALU8_OP_CLEAR_BITS_BY_MASK)
      |=> rsp_o.result == ($past(req_i.rd) & ~$past(req_i.k)))
      else $error("clear bits wrong");
   a_sign_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (rsp_o.valid && rsp_o.word) |-> rsp_o.flags.n == rsp_o.result_high[7] &&
      rsp_o.flags.z == ({rsp_o.result_high, rsp_o.result} == 16'h_0000) &&
      rsp_o.flags.s == (rsp_o.flags.n ^ rsp_o.flags.v))
      else $error("sign flag is not n xor v");
   a_neg_value: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_i.valid && !busy_o && req_i.op == alu8_pkg::ALU8_OP_NEG)
      |=> rsp_o.result == 8'h_00 - $past(req_i.rd) && rsp_o.flags.c == ($past(req_i.rd) != 8'h_00))
      else $error("negate wrong");

endmodule

/* alu8_tb.sv */
// Self-checking testbench for the 8-bit arithmetic and logic datapath.
`timescale 1ns/1ps
module testbench;
   typedef struct {
      alu8_pkg::alu8_op_t op;
      logic [7:0] rd;
      logic [7:0] rdh;
      logic [7:0] rr;
      logic [7:0] k;
      logic [5:0] fin;
      logic [7:0] res;
      logic [7:0] resh;
      logic [5:0] fl;
   } alu8_row_t;

   // ----------------------------------------
   // Cases: flag vectors are ordered h, s, v, n, z, c.
   // ----------------------------------------
   localparam int NROWS = 22;
   alu8_row_t rows [NROWS] = '{
      '{alu8_pkg::ALU8_OP_ADD, 8'h_0f, 8'h_00, 8'h_01, 8'h_00, 6'h_00, 8'h_10, 8'h_00, 6'h_20},
      '{alu8_pkg::ALU8_OP_ADC, 8'h_7f, 8'h_00, 8'h_00, 8'h_00, 6'h_01, 8'h_80, 8'h_00, 6'h_2c},
      '{alu8_pkg::ALU8_OP_ADD, 8'h_ff, 8'h_00, 8'h_01, 8'h_00, 6'h_00, 8'h_00, 8'h_00, 6'h_23},
      '{alu8_pkg::ALU8_OP_SUB, 8'h_10, 8'h_00, 8'h_01, 8'h_00, 6'h_00, 8'h_0f, 8'h_00, 6'h_20},
      '{alu8_pkg::ALU8_OP_SUBTRACT_CONSTANT, 8'h_80, 8'h_00, 8'h_00, 8'h_01, 6'h_00, 8'h_7f,
        8'h_00, 6'h_28},
      '{alu8_pkg::ALU8_OP_SBC, 8'h_00, 8'h_00, 8'h_00, 8'h_00, 6'h_01, 8'h_ff, 8'h_00, 6'h_25},
      '{alu8_pkg::ALU8_OP_SUBTRACT_CONST_WITH_CARRY, 8'h_05, 8'h_00, 8'h_00, 8'h_03, 6'h_01,
        8'h_01, 8'h_00, 6'h_00},
      '{alu8_pkg::ALU8_OP_ADD_IMMEDIATE_WORD, 8'h_c1, 8'h_ff, 8'h_00, 8'h_ff, 6'h_20, 8'h_00,
        8'h_00, 6'h_23},
      '{alu8_pkg::ALU8_OP_ADD_IMMEDIATE_WORD, 8'h_ff, 8'h_7f, 8'h_00, 8'h_01, 6'h_00, 8'h_00,
        8'h_80, 6'h_0c},
      '{alu8_pkg::ALU8_OP_SUBTRACT_IMMEDIATE_WORD, 8'h_00, 8'h_00, 8'h_00, 8'h_01, 6'h_00,
        8'h_ff, 8'h_ff, 6'h_15},
      '{alu8_pkg::ALU8_OP_SUBTRACT_IMMEDIATE_WORD, 8'h_00, 8'h_80, 8'h_00, 8'h_01, 6'h_00,
        8'h_ff, 8'h_7f, 6'h_18},
      '{alu8_pkg::ALU8_OP_AND, 8'h_f0, 8'h_00, 8'h_0f, 8'h_00, 6'h_3f, 8'h_00, 8'h_00, 6'h_33},
      '{alu8_pkg::ALU8_OP_ANDI, 8'h_f0, 8'h_00, 8'h_00, 8'h_80, 6'h_3f, 8'h_80, 8'h_00, 6'h_35},
      '{alu8_pkg::ALU8_OP_OR, 8'h_80, 8'h_00, 8'h_01, 8'h_00, 6'h_00, 8'h_81, 8'h_00, 6'h_04},
      '{alu8_pkg::ALU8_OP_ORI, 8'h_00, 8'h_00, 8'h_00, 8'h_00, 6'h_08, 8'h_00, 8'h_00, 6'h_02},
      '{alu8_pkg::ALU8_OP_BITWISE_EXCLUSIVE_OR, 8'h_aa, 8'h_00, 8'h_aa, 8'h_00, 6'h_21, 8'h_00,
        8'h_00, 6'h_23},
      '{alu8_pkg::ALU8_OP_COM, 8'h_00, 8'h_00, 8'h_00, 8'h_00, 6'h_20, 8'h_ff, 8'h_00, 6'h_25},
      '{alu8_pkg::ALU8_OP_NEG, 8'h_01, 8'h_00, 8'h_00, 8'h_00, 6'h_00, 8'h_ff, 8'h_00, 6'h_25},
      '{alu8_pkg::ALU8_OP_NEG, 8'h_80, 8'h_00, 8'h_00, 8'h_00, 6'h_00, 8'h_80, 8'h_00, 6'h_0d},
      '{alu8_pkg::ALU8_OP_NEG, 8'h_00, 8'h_00, 8'h_00, 8'h_00, 6'h_00, 8'h_00, 8'h_00, 6'h_02},
      '{alu8_pkg::ALU8_OP_SET_BITS_BY_MASK, 8'h_01, 8'h_00, 8'h_00, 8'h_80, 6'h_00, 8'h_81,
        8'h_00, 6'h_04},
      '{alu8_pkg::ALU8_OP_CLEAR_BITS_BY_MASK, 8'h_ff, 8'h_00, 8'h_00, 8'h_ff, 6'h_00, 8'h_00,
        8'h_00, 6'h_02}
   };

   logic clk;
   logic rst;
   alu8_pkg::alu8_req_t req;
   logic busy;
   alu8_pkg::alu8_rsp_t rsp;
   int errors = 0;
   int comparisons = 0;
   logic w;

   alu8_core dut (
      .clk_i(clk),
      .rst_i(rst),
      .req_i(req),
      .busy_o(busy),
      .rsp_o(rsp)
   );

   // ----------------------------------------
   // Compare and drive helpers
   // ----------------------------------------
   task automatic cmp1(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic cmp6(input logic [5:0] got, input logic [5:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic send(input int i);
      req.valid = 1'b1;
      req.op = rows[i].op;
      req.rd = rows[i].rd;
      req.rd_high = rows[i].rdh;
      req.rr = rows[i].rr;
      req.k = rows[i].k;
      req.flags_in = rows[i].fin;
   endtask

   task automatic check_answer(input int i, input logic word);
      cmp1(rsp.valid, 1'b1, "answer valid");
      cmp1(rsp.word, word, "word flag");
      cmp8(rsp.result, rows[i].res, "result");
      cmp8(rsp.result_high, rows[i].resh, "result high");
      cmp6(rsp.flags, rows[i].fl, "flags");
   endtask

   task automatic check_idle();
      cmp1(busy, 1'b0, "busy");
      cmp1(rsp.valid, 1'b0, "answer valid");
      cmp8(rsp.result, 8'h_00, "result");
      cmp6(rsp.flags, 6'h_00, "flags");
   endtask

   task automatic print_verdict();
      if (errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // The whole run is near 62 cycles, so 500 leaves ample margin for a hang.
   initial begin
      #(40 * 500);
      errors++;
      print_verdict();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      req = '0;
      repeat (4) @(negedge clk);
      check_idle();
      rst = 1'b0;
      for (int i = 0; i < NROWS; i++) begin
         w = (rows[i].op == alu8_pkg::ALU8_OP_ADD_IMMEDIATE_WORD) ||
             (rows[i].op == alu8_pkg::ALU8_OP_SUBTRACT_IMMEDIATE_WORD);
         send(i);
         @(negedge clk);
         if (w) begin
            // The request stays up while busy, so a taken duplicate would show below.
            cmp1(busy, 1'b1, "busy");
            cmp1(rsp.valid, 1'b0, "early answer");
            @(negedge clk);
            req.valid = 1'b0;
            check_answer(i, w);
         end else begin
            req.valid = 1'b0;
            check_answer(i, w);
         end
         @(negedge clk);
         cmp1(rsp.valid, 1'b0, "answer pulse");
         cmp1(busy, 1'b0, "busy after answer");
      end
      // Back-to-back byte operations.
      send(0);
      @(negedge clk);
      send(3);
      check_answer(0, 1'b0);
      @(negedge clk);
      req.valid = 1'b0;
      check_answer(3, 1'b0);
      // A byte request held through the busy cycle is taken right after it.
      send(7);
      @(negedge clk);
      send(3);
      @(negedge clk);
      check_answer(7, 1'b1);
      @(negedge clk);
      check_answer(3, 1'b0);
      // Reset in the middle of a word operation.
      send(9);
      @(negedge clk);
      rst = 1'b1;
      req.valid = 1'b0;
      @(negedge clk);
      check_idle();
      rst = 1'b0;
      send(0);
      @(negedge clk);
      // An undecoded operation answers with a zero result and leaves the flags alone.
      req.op = alu8_pkg::alu8_op_t'(5'h_1f);
      req.flags_in = 6'h_15;
      check_answer(0, 1'b0);
      @(negedge clk);
      req.valid = 1'b0;
      cmp1(rsp.valid, 1'b1, "unknown op answer");
      cmp8(rsp.result, 8'h_00, "unknown op result");
      cmp6(rsp.flags, 6'h_15, "unknown op flags");
      @(negedge clk);
      print_verdict();
   end
endmodule
